// ==== core/pcsc_ctrl.v ====
// Purpose: Control-signal side of a 16-bit card socket: strobes and card inputs.
// Assumes: Host requests arrive on clk; card inputs are asynchronous.
// Notes:   One cycle at a time; requests queue in a 16-word FIFO.
// Summary of operation
// - Drive I/O write strobe low during host I/O write cycles.
// - Drive output enable low during host memory read cycles.
// - Shared pin means ready only in memory-only interface mode.
// - Attribute select stays high through every common memory access.
// - Attribute select low limits strobes to attribute or I/O space.
// - Provide card reset output forcing a hard card reset.
// - Decode both voltage sense lines together into a voltage class.
// - Never complete a cycle while the card holds wait asserted.
// - Use write enable to latch write data into memory cards.
// - With an I/O card, write-protect pin means 16-bit port indication.
// - Assert I/O read strobe during host I/O read cycles.
// - First enable selects even bytes, second enable odd bytes.
`include "pcsc_map.vh"
module pcsc_ctrl #(
	parameter DEPTH = 16
) (
	input  wire                   clk,
	input  wire                   rst_n,
	input  wire [`PCSC_REQ_W-1:0] req_data,
	input  wire                   req_valid,
	output wire                   req_ready,
	input  wire                   io_mode,
	input  wire                   card_reset_req,
	output reg                    done_pulse,
	output reg                    done_is_io,
	output reg                    done_in_ack,
	output reg                    done_wide,
	output reg                    card_busy,
	output reg                    card_irq,
	output reg                    write_protect,
	output reg  [1:0]             volt_class,
	output reg                    io_write_strobe_n,
	output reg                    io_read_strobe_n,
	output reg                    mem_oe_n,
	output reg                    mem_we_n,
	output reg                    attr_sel_n,
	output reg                    even_byte_sel_n,
	output reg                    odd_byte_sel_n,
	output reg                    card_reset,
	input  wire                   ready_irq_pin,
	input  wire                   wait_n,
	input  wire                   wp_wide_pin_n,
	input  wire                   in_ack_n,
	input  wire                   volt_sense_a,
	input  wire                   volt_sense_b
);
	// ==========================================================
	// States, one-hot
	localparam [3:0] ST_IDLE   = 4'h1;
	localparam [3:0] ST_SETUP  = 4'h2;
	localparam [3:0] ST_STROBE = 4'h4;
	localparam [3:0] ST_HOLD   = 4'h8;

	reg  [3:0]             state_reg;
	reg  [3:0]             cnt_reg;
	reg  [`PCSC_REQ_W-1:0] cur_reg;
	reg  [5:0]             sync1_reg;
	reg  [5:0]             sync2_reg;
	reg                    io_wide_reg;
	wire [`PCSC_REQ_W-1:0] q_data;
	wire                   q_valid;
	wire                   q_ready;
	wire [1:0]             kind;
	wire                   s_ready;
	wire                   s_wait_n;
	wire                   s_wp_n;
	wire                   s_ack_n;

	// Classifies the voltage sense pair as one combination.
	function [1:0] vclass;
		input a;
		input b;
		begin
			case ({a, b})
				2'h0:    vclass = `PCSC_VCLS_LV;
				2'h1:    vclass = `PCSC_VCLS_3V;
				2'h2:    vclass = `PCSC_VCLS_5V;
				default: vclass = `PCSC_VCLS_OPEN;
			endcase
		end
	endfunction

	// ==========================================================
	// Request queue
	pcsc_fifo #(
		.WIDTH (`PCSC_REQ_W),
		.DEPTH (DEPTH),
		.AW    (4)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_data   (req_data),
		.in_valid  (req_valid),
		.in_ready  (req_ready),
		.out_data  (q_data),
		.out_valid (q_valid),
		.out_ready (q_ready)
	);

	// Pop only when idle, card out of reset and ready (memory mode).
	assign q_ready  = state_reg[0] & ~card_reset & (io_mode | s_ready);
	assign kind     = cur_reg[`PCSC_F_KIND_HI:`PCSC_F_KIND_LO];
	assign s_ready  = sync2_reg[0];
	assign s_wait_n = sync2_reg[1];
	assign s_wp_n   = sync2_reg[2];
	assign s_ack_n  = sync2_reg[3];

	// input synchronisers
	// Two flops on every card input; only the second stage is read.
	always @(posedge clk) begin
		if (!rst_n) begin
			sync1_reg <= 6'h3F;
			sync2_reg <= 6'h3F;
		end else begin
			sync1_reg <= {volt_sense_b, volt_sense_a, in_ack_n,
				wp_wide_pin_n, wait_n, ready_irq_pin};
			sync2_reg <= sync1_reg;
		end
	end

	// Status outputs decoded from synchronised card inputs; card reset registered from the host request.
	always @(posedge clk) begin
		if (!rst_n) begin
			card_busy     <= 1'b0;
			card_irq      <= 1'b0;
			write_protect <= 1'b0;
			volt_class    <= `PCSC_VCLS_OPEN;
			card_reset    <= 1'b1;
		end else begin
			card_busy     <= ~io_mode & ~s_ready;
			card_irq      <= io_mode & ~s_ready;
			write_protect <= ~io_mode & ~s_wp_n;
			volt_class    <= vclass(sync2_reg[4], sync2_reg[5]);
			card_reset    <= card_reset_req;
		end
	end

	// Cycle engine: setup with selects, strobe held until wait clears, hold.
	always @(posedge clk) begin
		if (!rst_n) begin
			state_reg   <= ST_IDLE;
			cnt_reg     <= 4'h0;
			cur_reg     <= {`PCSC_REQ_W{1'b0}};
			io_wide_reg <= 1'b0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (q_valid && q_ready) begin
						cur_reg   <= q_data;
						cnt_reg   <= `PCSC_SETUP_CYC;
						state_reg <= ST_SETUP;
					end
				end
				ST_SETUP: begin
					io_wide_reg <= io_mode & ~s_wp_n;
					if (cnt_reg == 4'h1) begin
						// recheck card ready
						// Ready drops only after the previous write ends, so read it again here.
						if (io_mode || s_ready) begin
							cnt_reg   <= `PCSC_STROBE_CYC;
							state_reg <= ST_STROBE;
						end
					end else begin
						cnt_reg <= cnt_reg - 4'h1;
					end
				end
				ST_STROBE: begin
					if (cnt_reg > 4'h1) begin
						cnt_reg <= cnt_reg - 4'h1;
					end else if (s_wait_n) begin
						cnt_reg   <= `PCSC_HOLD_CYC;
						state_reg <= ST_HOLD;
					end
				end
				ST_HOLD: begin
					if (cnt_reg == 4'h1) begin
						state_reg <= ST_IDLE;
					end else begin
						cnt_reg <= cnt_reg - 4'h1;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Pin drivers, registered; strobes only in the strobe state, one at a time.
	always @(posedge clk) begin
		if (!rst_n) begin
			io_write_strobe_n <= 1'b1;
			io_read_strobe_n  <= 1'b1;
			mem_oe_n          <= 1'b1;
			mem_we_n          <= 1'b1;
			attr_sel_n        <= 1'b1;
			even_byte_sel_n   <= 1'b1;
			odd_byte_sel_n    <= 1'b1;
			done_pulse        <= 1'b0;
			done_is_io        <= 1'b0;
			done_in_ack       <= 1'b0;
			done_wide         <= 1'b0;
		end else begin
			mem_oe_n          <= ~(state_reg[2] && kind == `PCSC_KIND_MEM_RD);
			mem_we_n          <= ~(state_reg[2] && kind == `PCSC_KIND_MEM_WR);
			io_read_strobe_n  <= ~(state_reg[2] && kind == `PCSC_KIND_IO_RD);
			io_write_strobe_n <= ~(state_reg[2] && kind == `PCSC_KIND_IO_WR);
			attr_sel_n        <= state_reg[0] | ~(kind[1] | cur_reg[`PCSC_F_ATTR]);
			even_byte_sel_n   <= state_reg[0] |
				(cur_reg[`PCSC_F_ODD] & ~cur_reg[`PCSC_F_WIDE]);
			odd_byte_sel_n    <= state_reg[0] |
				~(cur_reg[`PCSC_F_ODD] | cur_reg[`PCSC_F_WIDE]);
			// Completion pulse at the last hold cycle.
			done_pulse        <= state_reg[3] && cnt_reg == 4'h1;
			done_is_io        <= kind[1];
			done_in_ack       <= kind == `PCSC_KIND_IO_RD && !s_ack_n;
			done_wide         <= io_wide_reg;
		end
	end
endmodule

// ==== core/pcsc_map.vh ====
// Purpose: Named constants for the 16-bit card socket control strobes.
// Assumes: Included by core/pcsc_ctrl.v and by the bench top.
// Notes:   Cycle kinds, strobe timing counts and voltage classes.
`ifndef PCSC_MAP_VH
`define PCSC_MAP_VH
// ==========================================================
// Cycle kinds on the request port
`define PCSC_KIND_MEM_RD  2'h0
`define PCSC_KIND_MEM_WR  2'h1
`define PCSC_KIND_IO_RD   2'h2
`define PCSC_KIND_IO_WR   2'h3
// ==========================================================
// Timing counts in clock cycles
`define PCSC_SETUP_CYC    4'h2
`define PCSC_STROBE_CYC   4'h4
`define PCSC_HOLD_CYC     4'h1
// ==========================================================
// Voltage classes from the two sense lines
`define PCSC_VCLS_5V      2'h0
`define PCSC_VCLS_3V      2'h1
`define PCSC_VCLS_LV      2'h2
`define PCSC_VCLS_OPEN    2'h3
// ==========================================================
// Request word layout: kind, attribute, odd byte, wide, data
`define PCSC_REQ_W        21
`define PCSC_F_KIND_HI    20
`define PCSC_F_KIND_LO    19
`define PCSC_F_ATTR       18
`define PCSC_F_ODD        17
`define PCSC_F_WIDE       16
`endif

// ==== core/pcsc_fifo.v ====
// Purpose: Request FIFO in front of the socket cycle engine.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   Ready on the filling side reflects honest fullness.
// ==========================================================
// FIFO module
module pcsc_fifo #(
	parameter WIDTH = 21,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_reg;
	reg [AW-1:0]    rd_ptr_reg;
	reg [AW:0]      count_reg;
	reg [AW:0]      count_next;
	reg             in_ready_reg;
	wire            push;
	wire            pop;

	// Handshakes on both sides.
	assign in_ready  = in_ready_reg;
	assign out_valid = (count_reg != {(AW+1){1'b0}});
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem[rd_ptr_reg];

	// Next fill level; ready is registered from it so the filling side sees a flop.
	always @* begin
		count_next = count_reg;
		if (push && !pop) begin
			count_next = count_reg + 1'b1;
		end else if (pop && !push) begin
			count_next = count_reg - 1'b1;
		end
	end

	// Storage is not reset; pointers, fill count and ready carry the state.
	always @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	// Pointer and fill count update.
	always @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg  <= {(AW+1){1'b0}};
			in_ready_reg <= 1'b1;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			count_reg    <= count_next;
			in_ready_reg <= (count_next != DEPTH[AW:0]);
		end
	end
endmodule

// ==== bench/pcsc_chk.sv ====
// Purpose: Assertions on the socket strobes and status outputs.
// Assumes: Bound to pcsc_ctrl; one clock domain.
// Notes:   Wait is raw at the pin, so stretch checks allow for the sync delay.
// ====
// Checker
module pcsc_chk (
	input wire       clk,
	input wire       rst_n,
	input wire       io_mode,
	input wire       card_reset_req,
	input wire       done_pulse,
	input wire       card_busy,
	input wire       card_irq,
	input wire [1:0] volt_class,
	input wire       io_write_strobe_n,
	input wire       io_read_strobe_n,
	input wire       mem_oe_n,
	input wire       mem_we_n,
	input wire       attr_sel_n,
	input wire       card_reset,
	input wire       wait_n,
	input wire       volt_sense_a,
	input wire       volt_sense_b
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// Five cycles of wait held over a read strobe outlast the synchroniser.
	sequence wait_stretch;
		(!mem_oe_n && !wait_n)[*5];
	endsequence
	// Sense lines steady long enough to pass the synchroniser.
	sequence sense_steady;
		(rst_n && $stable(volt_sense_a) && $stable(volt_sense_b))[*6];
	endsequence
	a_no_overlap: assert property ((!mem_oe_n || !io_read_strobe_n) |->
		(mem_we_n && io_write_strobe_n)) else $error("read and write strobes overlap");
	a_oe_width: assert property ($fell(mem_oe_n) |=> !mem_oe_n[*3])
		else $error("read strobe too short");
	a_write_done: assert property ($rose(io_write_strobe_n) |-> done_pulse)
		else $error("no done after io write");
	a_io_attr: assert property ((!io_read_strobe_n || !io_write_strobe_n) |->
		!attr_sel_n) else $error("io strobe without attribute select");
	a_busy_mode: assert property (card_busy |-> !$past(io_mode))
		else $error("busy reported in io mode");
	a_irq_mode: assert property (card_irq |-> $past(io_mode))
		else $error("interrupt reported in memory mode");
	a_wait_hold: assert property (wait_stretch |=> !mem_oe_n)
		else $error("cycle ended under wait");
	a_wait_release: assert property ($rose(wait_n) && !mem_oe_n |-> ##[1:6] mem_oe_n)
		else $error("strobe stuck after wait");
	a_reset_follow: assert property ($past(rst_n) |-> card_reset == $past(card_reset_req))
		else $error("card reset not following request");
	a_volt_class: assert property (sense_steady |-> volt_class ==
		{~(volt_sense_a ^ volt_sense_b), volt_sense_b}) else $error("voltage class wrong");
endmodule

// ==== bench/pcsc_card.sv ====
// Purpose: Behavioural 16-bit card on the far side of the socket.
// Assumes: Strobes come from the controller; settings come from the bench.
// Notes:   Always answers as a wide port in io mode, so no narrow case.
// ====
// Card model
module pcsc_card (
	input  wire       clk,
	input  wire       io_mode,
	input  wire       oe_n,
	input  wire       we_n,
	input  wire       io_read_strobe_n_n,
	input  wire       io_write_strobe_n_n,
	input  wire [3:0] wait_len,
	input  wire       irq_want,
	input  wire       wp_sw,
	output logic      ready_irq,
	output logic      wait_n,
	output logic      wp_wide_n,
	output logic      in_ack_n
);
	timeunit 1ns;
	timeprecision 1ns;
	int   busy_cnt = 0;
	int   wait_cnt = 0;
	logic strb_d = 1'b0;
	logic we_d = 1'b1;
	logic strb;
	assign strb = !(oe_n && we_n && io_read_strobe_n_n && io_write_strobe_n_n);
	// shared ready pin
	// Busy shows as soon as the write strobe ends, before the counter is loaded.
	assign ready_irq = io_mode ? !irq_want : (busy_cnt == 0 && !(we_n && !we_d));
	assign wp_wide_n = io_mode ? 1'b0 : !wp_sw;
	assign in_ack_n = io_read_strobe_n_n;
	// stretch the cycle
	// Wait falls with the strobe itself, as a real card answers within one clock.
	assign wait_n = wait_cnt == 0 && !(strb && !strb_d && wait_len != 0);
	// Wait starts with each strobe; a memory write leaves the card busy a while.
	always @(posedge clk) begin
		strb_d <= strb;
		we_d <= we_n;
		if (strb && !strb_d) wait_cnt <= wait_len;
		else if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
		if (we_n && !we_d && !io_mode) busy_cnt <= 6;
		else if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
	end
endmodule

// ==== bench/test_pcsc_ctrl.sv ====
// Purpose: Self-checking bench for the socket control block.
// Assumes: Card model on the far side; inputs change at the falling edge.
// Notes:   Holding card reset keeps the queue from draining so it can fill.
`include "pcsc_map.vh"
// ====
// Bench top
module test_pcsc_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_n = 0, req_valid = 0, io_mode = 0, card_reset_req = 0;
	logic irq_want = 0, wp_sw = 0, volt_sense_a = 1, volt_sense_b = 0;
	logic [20:0] req_data = 0;
	logic [3:0] wait_len = 0;
	logic [4:0] r, k;
	logic [6:0] seen = 0;
	logic [4:0] expq[$];
	int n, miscompares = 0, num_checks = 0;
	wire req_ready, done_pulse, done_is_io, done_in_ack, done_wide, card_busy, card_irq;
	wire write_protect, io_write_strobe_n, io_read_strobe_n, mem_oe_n, mem_we_n, attr_sel_n;
	wire even_byte_sel_n, odd_byte_sel_n, card_reset, ready_irq_pin, wait_n, wp_wide_pin_n;
	wire in_ack_n;
	wire [1:0] volt_class;
	always #20 clk = ~clk;
	pcsc_ctrl uut (.*);
	pcsc_card card (.clk, .io_mode, .oe_n(mem_oe_n), .we_n(mem_we_n),
		.io_read_strobe_n_n(io_read_strobe_n), .io_write_strobe_n_n(io_write_strobe_n), .wait_len, .irq_want,
		.wp_sw, .ready_irq(ready_irq_pin), .wait_n, .wp_wide_n(wp_wide_pin_n), .in_ack_n);
	// Strobes and selects expected for {kind, attribute, odd, wide}.
	function automatic logic [6:0] exp_seen(logic [4:0] q);
		exp_seen = {q[4:3] == `PCSC_KIND_MEM_RD, q[4:3] == `PCSC_KIND_MEM_WR,
			q[4:3] == `PCSC_KIND_IO_RD, q[4:3] == `PCSC_KIND_IO_WR, q[2] | q[4],
			q[0] | !q[1], q[0] | q[1]};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Offer one request; the queue model keeps only what was taken.
	task automatic push(input logic [4:0] q, input logic ok);
		@(negedge clk);
		req_data = {q, 16'($urandom)};
		req_valid = 1;
		chk(req_ready, ok);
		if (req_ready) expq.push_back(q);
	endtask
	task automatic drain();
		@(negedge clk);
		req_valid = 0;
		for (n = 0; n < 4000 && expq.size() > 0; n++) @(negedge clk);
		if (expq.size() > 0) begin
			miscompares++;
			conclude();
		end
	endtask
	// Collect strobes seen during a cycle and judge them when it completes.
	always @(negedge clk) begin
		seen = seen | ~{mem_oe_n, mem_we_n, io_read_strobe_n, io_write_strobe_n,
			attr_sel_n, even_byte_sel_n, odd_byte_sel_n};
		if (done_pulse === 1'b1) begin
			r = expq.pop_front();
			chk({seen, done_is_io}, {exp_seen(r), r[4]});
			if (r[4]) chk(done_wide, io_mode);
			if (r[4:3] == `PCSC_KIND_IO_RD) chk(done_in_ack, 1);
			seen = 0;
		end
	end
	initial begin
		n = $urandom(32'h9FEA);
		repeat (16) @(negedge clk);
		rst_n = 1;
		// Single cycles of every kind, with random stretching by the card.
		for (int i = 0; i < 16; i++) begin
			k = 5'($urandom);
			k[4:3] = i[1:0];
			io_mode = k[4];
			wait_len = 4'($urandom);
			push(k, 1);
			drain();
			repeat (4) @(negedge clk);
			chk(card_busy, k[4:3] == `PCSC_KIND_MEM_WR);
		end
		// Fill the queue under card reset until it refuses, then drain it.
		for (int m = 0; m < 2; m++) begin
			io_mode = m[0];
			card_reset_req = 1;
			repeat (3) @(negedge clk);
			chk(card_reset, 1);
			for (int i = 0; i < 17; i++) push(5'($urandom), i < 16);
			card_reset_req = 0;
			drain();
		end
		for (int i = 0; i < 4; i++) begin
			{volt_sense_a, volt_sense_b} = i[1:0];
			repeat (6) @(negedge clk);
			chk(volt_class, {~^i[1:0], i[0]});
		end
		for (int i = 0; i < 4; i++) begin
			{io_mode, irq_want} = i[1:0];
			wp_sw = i[0];
			repeat (5) @(negedge clk);
			chk({card_irq, write_protect}, {i == 3, i == 1});
		end
		conclude();
	end
endmodule
bind pcsc_ctrl pcsc_chk chk_i (.*);
